// ---- include/cmp_out_pkg.sv ----
// Purpose: constants for the comparator output control block
// Assumes: byte-wide register port, one clock
// Notes:   bit positions and reset value of the control register
package cmp_out_pkg;
    localparam logic [19:0] OCR_ADDR      = 20'hfff62;
    localparam logic [7:0]  OCR_RESET     = 8'h00;
    localparam logic [7:0]  OCR_WMASK     = 8'hf7;
    localparam int          SPEED_BIT     = 7;
    localparam int          C1_POL_BIT    = 6;
    localparam int          C1_OE_BIT     = 5;
    localparam int          C1_IE_BIT     = 4;
    localparam int          C0_POL_BIT    = 2;
    localparam int          C0_OE_BIT     = 1;
    localparam int          C0_IE_BIT     = 0;
    localparam logic [1:0]  EDGE_RISE     = 2'h0;
    localparam logic [1:0]  EDGE_FALL     = 2'h1;
endpackage

// ---- design/cmp_channel.sv ----
// Purpose: one comparator channel: pin drive and edge interrupt
// Assumes: result already synchronised by the caller
// Notes:   edge select follows the filter register outside
`timescale 1ns/1ps
module cmp_channel
    import cmp_out_pkg::*;
(
    input  wire logic       clk,        // clock
    input  wire logic       rst,        // sync reset
    input  wire logic       result,     // synchronised compare result
    input  wire logic [1:0] edge_sel,   // {both, falling}
    input  wire logic       pol,        // invert pin
    input  wire logic       oe,         // pin enable
    input  wire logic       ie,         // irq enable
    output logic            pin_o,      // pin level
    output logic            pin_oe,     // pin enable
    output logic            irq         // one-cycle request
);
    logic prev_r;
    logic pin_r, oe_r, irq_r;
    logic prev_nxt, pin_nxt, oe_nxt, irq_nxt;
    logic rise, fall, hit;

    always_comb begin
        rise     = result & ~prev_r;
        fall     = ~result & prev_r;
        hit      = edge_sel[1] ? (rise | fall)
                 : (edge_sel == EDGE_FALL) ? fall : rise;
        prev_nxt = result;
        pin_nxt  = result ^ pol;
        oe_nxt   = oe;
        irq_nxt  = ie & hit;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prev_r <= 1'b0;
            pin_r  <= 1'b0;
            oe_r   <= 1'b0;
            irq_r  <= 1'b0;
        end else begin
            prev_r <= prev_nxt;
            pin_r  <= pin_nxt;
            oe_r   <= oe_nxt;
            irq_r  <= irq_nxt;
        end
    end

    assign pin_o  = pin_r;
    assign pin_oe = oe_r;
    assign irq    = irq_r;
endmodule

// ---- design/comparator_output_control.sv ----
// Functional notes
// - any reset clears the control register to zero
// - register takes byte writes and single-bit manipulations
// - bit 7 picks shared response speed: 0 low, 1 high
// - bits 6 and 2 invert comparator 1 and 0 pin outputs
// - bits 5 and 1 enable driving comparator 1 and 0 pins
// - bits 4 and 0 gate comparator 1 and 0 interrupt requests
// - enabled request fires on the chosen edge of the result
//
// Purpose: control register for two comparators, pin and irq gating
// Assumes: byte port with write strobe and per-bit write mask
// Notes:   results arrive asynchronously and are double flopped
`timescale 1ns/1ps
module comparator_output_control
    import cmp_out_pkg::*;
(
    input  wire logic       CLK,            // 50 MHz clock
    input  wire logic       RST,            // sync reset, high
    input  wire logic [19:0] ADDR,          // register address
    input  wire logic       WR,             // write strobe
    input  wire logic [7:0] WMASK,          // bits touched by write
    input  wire logic [7:0] WDATA,          // write data
    output logic      [7:0] RDATA,          // read data, registered
    input  wire logic [1:0] CMP_RESULT,     // raw compare results
    input  wire logic [1:0] CMP_RUN,        // operation enable per cmp
    input  wire logic [3:0] EDGE_SEL,       // {c1 both,fall,c0 both,fall}
    output logic            SPEED_HIGH,     // response speed select
    output logic [1:0]      RESULT_PIN,     // pin levels
    output logic [1:0]      RESULT_PIN_OE,  // pin drive enables
    output logic [1:0]      DETECT_IRQ      // one-cycle requests
);
    logic [7:0] ocr_r, ocr_nxt;
    logic [7:0] rd_r, rd_nxt;
    logic [1:0] sync1_r, sync2_r;
    logic       spd_r, spd_nxt;

    // ==========================================================
    // address decode
    // ==========================================================
    // shared by the write path, the read path and the checks
    function automatic logic ocr_hit(input logic [19:0] a);
        return (a == OCR_ADDR);
    endfunction

    // ==========================================================
    // register
    // ==========================================================
    always_comb begin
        ocr_nxt = ocr_r;
        if (WR && ocr_hit(ADDR))
            ocr_nxt = (ocr_r & ~WMASK) | (WDATA & WMASK);
        ocr_nxt = ocr_nxt & OCR_WMASK;
        rd_nxt  = ocr_hit(ADDR) ? ocr_r : 8'h00;
        spd_nxt = ocr_r[SPEED_BIT];
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ocr_r   <= OCR_RESET;
            rd_r    <= 8'h00;
            spd_r   <= 1'b0;
            sync1_r <= 2'h0;
            sync2_r <= 2'h0;
        end else begin
            ocr_r   <= ocr_nxt;
            rd_r    <= rd_nxt;
            spd_r   <= spd_nxt;
            sync1_r <= CMP_RESULT;
            sync2_r <= sync1_r;
        end
    end

    assign RDATA      = rd_r;
    assign SPEED_HIGH = spd_r;

    // ==========================================================
    // channels
    // ==========================================================
    // per channel pin and irq
    cmp_channel u_ch0 (
        .clk      (CLK),
        .rst      (RST),
        .result   (sync2_r[0]),
        .edge_sel (EDGE_SEL[1:0]),
        .pol      (ocr_r[C0_POL_BIT]),
        .oe       (ocr_r[C0_OE_BIT]),
        .ie       (ocr_r[C0_IE_BIT]),
        .pin_o    (RESULT_PIN[0]),
        .pin_oe   (RESULT_PIN_OE[0]),
        .irq      (DETECT_IRQ[0])
    );
    cmp_channel u_ch1 (
        .clk      (CLK),
        .rst      (RST),
        .result   (sync2_r[1]),
        .edge_sel (EDGE_SEL[3:2]),
        .pol      (ocr_r[C1_POL_BIT]),
        .oe       (ocr_r[C1_OE_BIT]),
        .ie       (ocr_r[C1_IE_BIT]),
        .pin_o    (RESULT_PIN[1]),
        .pin_oe   (RESULT_PIN_OE[1]),
        .irq      (DETECT_IRQ[1])
    );

    // ==========================================================
    // checks
    // ==========================================================
    property p_reset_zero;
        @(posedge CLK) RST |=> (ocr_r == 8'h00);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("register not cleared by reset");

    property p_bit_write;
        @(posedge CLK) disable iff (RST)
        (WR && ADDR == OCR_ADDR && WMASK == 8'h01)
        |=> (ocr_r[7:1] == $past(ocr_r[7:1]));
    endproperty
    a_bit_write: assert property (p_bit_write)
        else $error("single-bit write disturbed other bits");

    property p_speed;
        @(posedge CLK) disable iff (RST)
        1 |=> (SPEED_HIGH == $past(ocr_r[SPEED_BIT]));
    endproperty
    a_speed: assert property (p_speed)
        else $error("speed output does not follow bit 7");

    property p_speed_idle;
        @(posedge CLK) disable iff (RST)
        $changed(ocr_r[SPEED_BIT]) |-> ($past(CMP_RUN) == 2'h0);
    endproperty
    a_speed_idle: assert property (p_speed_idle)
        else $error("speed changed while comparator running");

    property p_pol;
        @(posedge CLK) disable iff (RST)
        1 |=> (RESULT_PIN[0] == ($past(sync2_r[0]) ^ $past(ocr_r[2])));
    endproperty
    a_pol: assert property (p_pol)
        else $error("pin 0 polarity wrong");

    property p_oe;
        @(posedge CLK) disable iff (RST)
        1 |=> (RESULT_PIN_OE[1] == $past(ocr_r[C1_OE_BIT]));
    endproperty
    a_oe: assert property (p_oe)
        else $error("pin 1 enable wrong");

    property p_irq_gate;
        @(posedge CLK) disable iff (RST)
        !$past(ocr_r[C0_IE_BIT]) |-> !DETECT_IRQ[0];
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq 0 passed while disabled");

    property p_both_edge;
        @(posedge CLK) disable iff (RST)
        (ocr_r[C1_IE_BIT] && EDGE_SEL[3] && $changed(sync2_r[1])
         && !$past(RST)) |=> DETECT_IRQ[1];
    endproperty
    a_both_edge: assert property (p_both_edge)
        else $error("irq 1 missed on edge");

    property p_bit3;
        @(posedge CLK) disable iff (RST) ocr_r[3] == 1'b0;
    endproperty
    a_bit3: assert property (p_bit3)
        else $error("bit 3 not zero");

    property p_reset_out;
        @(posedge CLK) RST |=> (DETECT_IRQ == 2'h0 && RESULT_PIN_OE == 2'h0
                                && !SPEED_HIGH && RDATA == 8'h00);
    endproperty
    a_reset_out: assert property (p_reset_out)
        else $error("outputs not cleared by reset");

    property p_byte_write;
        @(posedge CLK) disable iff (RST)
        (WR && ocr_hit(ADDR) && WMASK == 8'hff)
        |=> (ocr_r == ($past(WDATA) & OCR_WMASK));
    endproperty
    a_byte_write: assert property (p_byte_write)
        else $error("byte write did not land");

    // the read port answers one cycle after the address
    property p_read;
        @(posedge CLK) disable iff (RST)
        ($past(ADDR) == OCR_ADDR) |-> (RDATA == $past(ocr_r));
    endproperty
    a_read: assert property (p_read)
        else $error("read data does not show register");

    property p_read_other;
        @(posedge CLK) disable iff (RST)
        ($past(ADDR) != OCR_ADDR) |-> (RDATA == 8'h00);
    endproperty
    a_read_other: assert property (p_read_other)
        else $error("read data not zero off address");

    property p_pol1;
        @(posedge CLK) disable iff (RST)
        1 |=> (RESULT_PIN[1]
               == ($past(sync2_r[1]) ^ $past(ocr_r[C1_POL_BIT])));
    endproperty
    a_pol1: assert property (p_pol1)
        else $error("pin 1 polarity wrong");

    property p_oe0;
        @(posedge CLK) disable iff (RST)
        1 |=> (RESULT_PIN_OE[0] == $past(ocr_r[C0_OE_BIT]));
    endproperty
    a_oe0: assert property (p_oe0)
        else $error("pin 0 enable wrong");

    property p_irq_gate1;
        @(posedge CLK) disable iff (RST)
        !$past(ocr_r[C1_IE_BIT]) |-> !DETECT_IRQ[1];
    endproperty
    a_irq_gate1: assert property (p_irq_gate1)
        else $error("irq 1 passed while disabled");

    property p_rise0;
        @(posedge CLK) disable iff (RST)
        (ocr_r[C0_IE_BIT] && EDGE_SEL[1:0] == EDGE_RISE
         && $rose(sync2_r[0]) && !$past(RST)) |=> DETECT_IRQ[0];
    endproperty
    a_rise0: assert property (p_rise0)
        else $error("irq 0 missed on rising edge");

    property p_fall0;
        @(posedge CLK) disable iff (RST)
        (ocr_r[C0_IE_BIT] && EDGE_SEL[1:0] == EDGE_FALL
         && $fell(sync2_r[0]) && !$past(RST)) |=> DETECT_IRQ[0];
    endproperty
    a_fall0: assert property (p_fall0)
        else $error("irq 0 missed on falling edge");

    // a request without a result change would be a false edge
    property p_irq_cause1;
        @(posedge CLK) disable iff (RST)
        DETECT_IRQ[1] |-> ($past(sync2_r[1]) != $past(sync2_r[1], 2));
    endproperty
    a_irq_cause1: assert property (p_irq_cause1)
        else $error("irq 1 raised without an edge");
endmodule

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for comparator output control
// Assumes: cmp_out_pkg compiled first; run low whenever speed changes
// Notes:   byte model in bench; irq pulses counted, not timed
`timescale 1ns/1ps
module tb_top
    import cmp_out_pkg::*;
    ;
    logic        clk;
    logic        rst;
    logic        wr;
    logic        spd;
    logic [19:0] addr;
    logic [7:0]  wmask;
    logic [7:0]  wdata;
    logic [7:0]  rdata;
    logic [7:0]  mdl;
    logic [1:0]  res;
    logic [1:0]  o;
    logic [1:0]  n;
    logic [1:0]  pin;
    logic [1:0]  pin_oe;
    logic [1:0]  irq;
    logic [3:0]  esel;
    logic [1:0]  run;
    int          bad_count = 0;
    int          tests_run = 0;
    int          ic0 = 0;
    int          ic1 = 0;
    int          c0;
    int          c1;
    int          e0;
    int          e1;

    // run is driven so the speed-change check sees both levels
    comparator_output_control DUT (.CLK(clk), .RST(rst), .ADDR(addr),
        .WR(wr), .WMASK(wmask), .WDATA(wdata), .RDATA(rdata),
        .CMP_RESULT(res), .CMP_RUN(run), .EDGE_SEL(esel),
        .SPEED_HIGH(spd), .RESULT_PIN(pin), .RESULT_PIN_OE(pin_oe),
        .DETECT_IRQ(irq));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk) begin
        ic0 <= ic0 + irq[0];
        ic1 <= ic1 + irq[1];
    end

    // ============================================================
    // tasks
    task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            bad_count++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask

    task final_report;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task wreg(input logic [19:0] a, input logic [7:0] m, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wr <= 1'b1;
        wmask <= m;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= OCR_ADDR;
        if (a == OCR_ADDR)
            mdl = ((mdl & ~m) | (d & m)) & OCR_WMASK;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task state_chk;
        logic [1:0] oe_exp;
        logic [1:0] pol_exp;
        oe_exp  = {mdl[C1_OE_BIT], mdl[C0_OE_BIT]};
        pol_exp = {mdl[C1_POL_BIT], mdl[C0_POL_BIT]};
        chk("reg", rdata, mdl);
        chk("speed", 8'(spd), 8'(mdl[SPEED_BIT]));
        chk("pin_oe", 8'(pin_oe), 8'(oe_exp));
        chk("pin", 8'(pin), 8'(res ^ pol_exp));
    endtask

    function automatic int hit(logic a, logic b, logic [1:0] e, logic ie);
        return int'(ie && a != b && (e[1] || (e[0] ? !b : b)));
    endfunction

    // ============================================================
    // sequence
    initial begin
        #100000;
        bad_count++;
        final_report;
    end

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        addr = OCR_ADDR;
        wmask = 8'h00;
        wdata = 8'h00;
        res = 2'h0;
        esel = 4'h0;
        run = 2'h0;
        mdl = OCR_RESET;
        void'($urandom(32'h214423e6));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        state_chk;
        chk("irq", 8'(ic0 + ic1), 8'h00);
        chk("irq_lvl", 8'(irq), 8'h00);
        for (int i = 0; i < 6; i++) begin
            wreg(OCR_ADDR, 8'hff, 8'($urandom));
            state_chk;
        end
        for (int i = 0; i < 8; i++) begin
            wreg(OCR_ADDR, 8'h01 << i, 8'hff);
            state_chk;
            wreg(OCR_ADDR, 8'h01 << i, 8'h00);
            state_chk;
        end
        // other addresses leave the byte alone
        wreg(OCR_ADDR + 20'h1, 8'hff, 8'hff);
        state_chk;
        // reads elsewhere return zero
        @(posedge clk);
        addr <= OCR_ADDR + 20'h1;
        repeat (2) @(posedge clk);
        #1;
        chk("rd_other", rdata, 8'h00);
        addr <= OCR_ADDR;
        run <= 2'h3;
        for (int k = 0; k < 8; k++) begin
            esel <= {k[1:0], k[1:0]};
            wreg(OCR_ADDR, 8'h11, {3'h0, k[2], 3'h0, k[2]});
            repeat (4) begin
                o = res;
                n = 2'($urandom);
                c0 = ic0;
                c1 = ic1;
                @(posedge clk);
                res <= n;
                repeat (6) @(posedge clk);
                #1;
                e0 = hit(o[0], n[0], esel[1:0], mdl[C0_IE_BIT]);
                e1 = hit(o[1], n[1], esel[3:2], mdl[C1_IE_BIT]);
                chk("irq0", 8'(ic0 - c0), 8'(e0));
                chk("irq1", 8'(ic1 - c1), 8'(e1));
                state_chk;
            end
        end
        // stop both before speed is rewritten
        run <= 2'h0;
        wreg(OCR_ADDR, 8'hff, 8'hf7);
        state_chk;
        // reset with both comparators stopped (run low) and bits set
        c0 = ic0;
        c1 = ic1;
        @(posedge clk);
        res <= 2'h0;
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        mdl = OCR_RESET;
        repeat (4) @(posedge clk);
        #1;
        state_chk;
        chk("irq_rst", 8'(ic0 + ic1 - c0 - c1), 8'h00);
        chk("irq_lvl", 8'(irq), 8'h00);
        final_report;
    end
endmodule
